/* logic/gpio_port_pkg.sv */
package gpio_port_pkg;
  localparam int          PIN_COUNT   = 16;
  localparam int          ADDR_WIDTH  = 8;
  localparam int          DATA_WIDTH  = 32;
  // base register offsets; each writable one has clear/set/invert aliases above it
  localparam logic [7:0]  ANALOG_SELECT_OFS   = 8'h00;
  localparam logic [7:0]  PIN_DIRECTION_OFS   = 8'h10;
  localparam logic [7:0]  PIN_LEVEL_OFS       = 8'h20;
  localparam logic [7:0]  OUTPUT_LATCH_OFS    = 8'h30;
  localparam logic [7:0]  OPEN_DRAIN_OFS      = 8'h40;
  localparam logic [7:0]  PULLUP_OFS          = 8'h50;
  localparam logic [7:0]  PULLDOWN_OFS        = 8'h60;
  localparam logic [7:0]  CHANGE_CONTROL_OFS  = 8'h70;
  localparam logic [7:0]  CHANGE_ENABLE_OFS   = 8'h80;
  localparam logic [7:0]  CHANGE_SEEN_OFS     = 8'h90;
  localparam logic [7:0]  IRQ_STATUS_OFS      = 8'hA0;
  localparam logic [7:0]  IRQ_MASK_OFS        = 8'hB0;
  // alias decode: low nibble selects the operation
  localparam logic [3:0]  OP_WRITE   = 4'h0;
  localparam logic [3:0]  OP_CLEAR   = 4'h4;
  localparam logic [3:0]  OP_SET     = 4'h8;
  localparam logic [3:0]  OP_INVERT  = 4'hC;
  // field positions in the change-notice control register
  localparam int          CTRL_ON_BIT   = 15;
  localparam int          CTRL_SIDL_BIT = 13;
  // reset values
  localparam logic [15:0] ANALOG_SELECT_RST = 16'hFFFF;
  localparam logic [15:0] PIN_DIRECTION_RST = 16'hFFFF;
  localparam logic [15:0] ZERO_RST          = 16'h0000;
  localparam logic [31:0] UNMAPPED_DATA     = 32'h0000_0000;
  // irq status bit
  localparam int          IRQ_CHANGE_BIT = 0;
endpackage : gpio_port_pkg

/* logic/pin_sync.sv */
`timescale 1ns/10ps
module pin_sync (
  input  wire logic        ref_clk,   // clock
  input  wire logic        rstn,      // async reset, low
  input  wire logic [15:0] pinAsync,  // raw pin levels
  output logic      [15:0] pinSync    // synchronised levels
);
  logic [15:0] stage1_r;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stage1_r <= gpio_port_pkg::ZERO_RST;
      pinSync  <= gpio_port_pkg::ZERO_RST;
    end else begin
      stage1_r <= pinAsync;
      pinSync  <= stage1_r;
    end
  end
endmodule : pin_sync

/* logic/port_io_change_notify.sv */
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module port_io_change_notify (
  input  wire logic        ref_clk,     // peripheral clock, 20 MHz
  input  wire logic        rstn,        // async reset, low
  input  wire logic [7:0]  regAddr,     // register byte address
  input  wire logic [31:0] regWdata,    // write data
  input  wire logic        regWr,       // write strobe
  input  wire logic        regRd,       // read strobe
  output logic      [31:0] regRdata,    // read data, cycle after strobe
  input  wire logic [15:0] pinIn,       // pin levels from pads
  output logic      [15:0] pinOut,      // pad output value
  output logic      [15:0] pinOe,       // pad output enable
  output logic      [15:0] pullUpEn,    // weak pull-up enables
  output logic      [15:0] pullDownEn,  // weak pull-down enables
  output logic      [15:0] analogEn,    // pad analog path enables
  output logic             changeIrq,   // change-notice request level
  output logic             irq          // masked interrupt level
);
  logic [15:0] analogSel_r;
  logic [15:0] pinDir_r;
  logic [15:0] outLatch_r;
  logic [15:0] openDrain_r;
  logic [15:0] pullUp_r;
  logic [15:0] pullDown_r;
  logic [15:0] changeCtl_r;
  logic [15:0] changeEn_r;
  logic [15:0] changeSeen_r;
  logic [15:0] lastRead_r;
  logic [15:0] irqStatus_r;
  logic [15:0] irqMask_r;
  logic [31:0] regRdata_nxt;
  logic [15:0] pinSync;
  logic [15:0] pinLevel;
  logic [15:0] wdata16;
  logic [3:0]  aliasOp;
  logic [7:0]  baseAddr;
  logic        levelRead;
  logic        changeOn;
  logic        changeReq;
  logic [15:0] changeDiff;
  logic [15:0] irqEvent;
  logic [15:0] analogIn;
  logic        statusRead;
  // one write strobe per writable base register (none for change seen or irq status), alias operations included
  logic        analogSelWe;
  logic        pinDirWe;
  logic        outLatchWe;
  logic        pinLevelWe;
  logic        openDrainWe;
  logic        pullUpWe;
  logic        pullDownWe;
  logic        changeCtlWe;
  logic        changeEnWe;
  logic        irqMaskWe;

  assign wdata16  = regWdata[15:0];
  assign aliasOp  = regAddr[3:0];
  assign baseAddr = {regAddr[7:4], 4'h0};

  // applies a plain write or one of the atomic alias operations
  function automatic logic [15:0] apply_op(input logic [15:0] cur,
                                           input logic [15:0] val,
                                           input logic [3:0]  op);
    logic [15:0] res;
    res = cur;
    unique case (op)
      gpio_port_pkg::OP_WRITE:  res = val;
      gpio_port_pkg::OP_CLEAR:  res = cur & ~val;
      gpio_port_pkg::OP_SET:    res = cur | val;
      gpio_port_pkg::OP_INVERT: res = cur ^ val;
      default:                  res = cur;
    endcase
    return res;
  endfunction : apply_op

  function automatic logic hit(input logic [7:0] base,
                               input logic [7:0] ofs);
    return regWr && (base == ofs);
  endfunction : hit

  // register reads that have side effects
  function automatic logic read_hit(input logic [7:0] base,
                                    input logic [7:0] ofs);
    return regRd && (base == ofs) && (aliasOp == gpio_port_pkg::OP_WRITE);
  endfunction : read_hit

  // pins cross into this clock through two flops
  pin_sync u_pin_sync (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .pinAsync (pinIn),
    .pinSync  (pinSync)
  );

  // a write to an unused low nibble leaves the register as it is
  assign analogSelWe = hit(baseAddr, gpio_port_pkg::ANALOG_SELECT_OFS);
  assign pinDirWe    = hit(baseAddr, gpio_port_pkg::PIN_DIRECTION_OFS);
  assign outLatchWe  = hit(baseAddr, gpio_port_pkg::OUTPUT_LATCH_OFS);
  assign pinLevelWe  = hit(baseAddr, gpio_port_pkg::PIN_LEVEL_OFS);
  assign openDrainWe = hit(baseAddr, gpio_port_pkg::OPEN_DRAIN_OFS);
  assign pullUpWe    = hit(baseAddr, gpio_port_pkg::PULLUP_OFS);
  assign pullDownWe  = hit(baseAddr, gpio_port_pkg::PULLDOWN_OFS);
  assign changeCtlWe = hit(baseAddr, gpio_port_pkg::CHANGE_CONTROL_OFS);
  assign changeEnWe  = hit(baseAddr, gpio_port_pkg::CHANGE_ENABLE_OFS);
  assign irqMaskWe   = hit(baseAddr, gpio_port_pkg::IRQ_MASK_OFS);

  // analog inputs read low
  assign analogIn   = analogSel_r & pinDir_r;
  assign pinLevel   = pinSync & ~analogIn;
  assign levelRead  = read_hit(baseAddr, gpio_port_pkg::PIN_LEVEL_OFS);
  assign statusRead = read_hit(baseAddr, gpio_port_pkg::IRQ_STATUS_OFS);
  assign changeOn   = changeCtl_r[gpio_port_pkg::CTRL_ON_BIT];

  // analog select comes up all ones so every analog pin starts analog
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      analogSel_r <= gpio_port_pkg::ANALOG_SELECT_RST;
    end else if (analogSelWe) begin
      analogSel_r <= apply_op(analogSel_r, wdata16, aliasOp);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pinDir_r <= gpio_port_pkg::PIN_DIRECTION_RST;
    end else if (pinDirWe) begin
      pinDir_r <= apply_op(pinDir_r, wdata16, aliasOp);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      outLatch_r <= gpio_port_pkg::ZERO_RST;
    end else if (outLatchWe) begin
      outLatch_r <= apply_op(outLatch_r, wdata16, aliasOp);
    end else if (pinLevelWe) begin
      outLatch_r <= apply_op(outLatch_r, wdata16, aliasOp);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      openDrain_r <= gpio_port_pkg::ZERO_RST;
    end else if (openDrainWe) begin
      openDrain_r <= apply_op(openDrain_r, wdata16, aliasOp);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pullUp_r <= gpio_port_pkg::ZERO_RST;
    end else if (pullUpWe) begin
      pullUp_r <= apply_op(pullUp_r, wdata16, aliasOp);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pullDown_r <= gpio_port_pkg::ZERO_RST;
    end else if (pullDownWe) begin
      pullDown_r <= apply_op(pullDown_r, wdata16, aliasOp);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      changeCtl_r <= gpio_port_pkg::ZERO_RST;
    end else if (changeCtlWe) begin
      changeCtl_r <= apply_op(changeCtl_r, wdata16, aliasOp);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      changeEn_r <= gpio_port_pkg::ZERO_RST;
    end else if (changeEnWe) begin
      changeEn_r <= apply_op(changeEn_r, wdata16, aliasOp);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irqMask_r <= gpio_port_pkg::ZERO_RST;
    end else if (irqMaskWe) begin
      irqMask_r <= apply_op(irqMask_r, wdata16, aliasOp);
    end
  end

  // the flag compares the synchronised level with the value returned by the
  // last level read; it is sticky, so a pin that toggles back still counts
  assign changeDiff = pinLevel ^ lastRead_r;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lastRead_r <= gpio_port_pkg::ZERO_RST;
    end else if (levelRead) begin
      lastRead_r <= pinLevel;
    end
  end

  // a read captures the present level, so nothing differs from it in that
  // cycle and the clear drops no change; detection has no clock gate of its own
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      changeSeen_r <= gpio_port_pkg::ZERO_RST;
    end else if (levelRead) begin
      changeSeen_r <= gpio_port_pkg::ZERO_RST;
    end else if (changeOn) begin
      changeSeen_r <= changeSeen_r | changeDiff;
    end
  end

  assign changeReq = |(changeSeen_r & changeEn_r);

  always_comb begin
    irqEvent                                = gpio_port_pkg::ZERO_RST;
    irqEvent[gpio_port_pkg::IRQ_CHANGE_BIT] = changeReq;
  end

  // set wins over the clearing read, so an event in that cycle is kept
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irqStatus_r <= gpio_port_pkg::ZERO_RST;
    end else if (statusRead) begin
      irqStatus_r <= irqEvent;
    end else begin
      irqStatus_r <= irqStatus_r | irqEvent;
    end
  end

  assign changeIrq = changeReq;
  assign irq       = |(irqStatus_r & irqMask_r);

  // pad drive: output when direction is 0; open drain never drives high
  always_comb begin
    for (int i = 0; i < gpio_port_pkg::PIN_COUNT; i++) begin
      pinOut[i] = outLatch_r[i];
      pinOe[i]  = !pinDir_r[i] && !(openDrain_r[i] && outLatch_r[i]);
    end
  end

  assign pullUpEn   = pullUp_r;
  assign pullDownEn = pullDown_r;
  assign analogEn   = analogSel_r;

  // unmapped base addresses read as zero
  function automatic logic [15:0] read_value(input logic [7:0] base);
    logic [15:0] val;
    val = gpio_port_pkg::ZERO_RST;
    unique case (base)
      gpio_port_pkg::ANALOG_SELECT_OFS:  val = analogSel_r;
      gpio_port_pkg::PIN_DIRECTION_OFS:  val = pinDir_r;
      gpio_port_pkg::PIN_LEVEL_OFS:      val = pinLevel;
      gpio_port_pkg::OUTPUT_LATCH_OFS:   val = outLatch_r;
      gpio_port_pkg::OPEN_DRAIN_OFS:     val = openDrain_r;
      gpio_port_pkg::PULLUP_OFS:         val = pullUp_r;
      gpio_port_pkg::PULLDOWN_OFS:       val = pullDown_r;
      gpio_port_pkg::CHANGE_CONTROL_OFS: val = changeCtl_r;
      gpio_port_pkg::CHANGE_ENABLE_OFS:  val = changeEn_r;
      gpio_port_pkg::CHANGE_SEEN_OFS:    val = changeSeen_r;
      gpio_port_pkg::IRQ_STATUS_OFS:     val = irqStatus_r;
      gpio_port_pkg::IRQ_MASK_OFS:       val = irqMask_r;
      default:                           val = gpio_port_pkg::ZERO_RST;
    endcase
    return val;
  endfunction : read_value

  always_comb begin
    regRdata_nxt = gpio_port_pkg::UNMAPPED_DATA;
    if (aliasOp == gpio_port_pkg::OP_WRITE) begin
      regRdata_nxt[15:0] = read_value(baseAddr);
    end
  end

  // alias reads return zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      regRdata <= gpio_port_pkg::UNMAPPED_DATA;
    else if (regRd)
      regRdata <= regRdata_nxt;
    else
      regRdata <= gpio_port_pkg::UNMAPPED_DATA;
  end
endmodule : port_io_change_notify

/* dv/pin_partner.sv */
`timescale 1ns/10ps
module pin_partner (
  input  wire logic        ref_clk, // clock
  input  wire logic [15:0] drvVal,  // pad output value
  input  wire logic [15:0] drvEn,   // pad output enable
  input  wire logic [15:0] pullUp,  // weak pull-ups
  input  wire logic [15:0] pullDn,  // weak pull-downs
  input  wire logic [15:0] extVal,  // attached circuit level
  input  wire logic [15:0] extEn,   // attached circuit drives
  output logic      [15:0] level    // resolved pad level
);
  logic [15:0] last = 16'h0000;
  always_ff @(posedge ref_clk) begin
    last <= level;
  end
  // a floating pad toggles so a stale value is never read
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (extEn[i]) level[i] = extVal[i];
      else if (drvEn[i]) level[i] = drvVal[i];
      else if (pullUp[i]) level[i] = 1'b1;
      else if (pullDn[i]) level[i] = 1'b0;
      else level[i] = ~last[i];
    end
  end
endmodule : pin_partner

/* dv/port_io_change_notify_sva.sv */
`timescale 1ns/10ps
module port_io_change_notify_sva (
  input wire logic        ref_clk,    // clock
  input wire logic        rstn,       // reset, low
  input wire logic [7:0]  regAddr,    // address
  input wire logic [31:0] regWdata,   // write data
  input wire logic        regWr,      // write
  input wire logic        regRd,      // read
  input wire logic [31:0] regRdata,   // read data
  input wire logic [15:0] pinOut,     // pad value
  input wire logic [15:0] pinOe,      // pad enable
  input wire logic [15:0] pullUpEn,   // pull-ups
  input wire logic [15:0] pullDownEn, // pull-downs
  input wire logic [15:0] analogEn    // analog paths
);
  logic [15:0] wd;
  assign wd = regWdata[15:0];
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  property p_reset_state;
    $rose(rstn) |-> pinOe == 16'h0000 && analogEn == 16'hFFFF;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad reset state");
  property p_dir_input;
    regWr && regAddr == 8'h10 |=> (pinOe & $past(wd)) == 16'h0000;
  endproperty
  a_dir_input: assert property (p_dir_input) else $error("input pin driven");
  property p_latch_write;
    regWr && regAddr == 8'h30 |=> pinOut == $past(wd);
  endproperty
  a_latch_write: assert property (p_latch_write) else $error("latch write lost");
  property p_level_write;
    regWr && regAddr == 8'h20 |=> pinOut == $past(wd);
  endproperty
  a_level_write: assert property (p_level_write) else $error("level write lost");
  property p_latch_set;
    regWr && regAddr == 8'h38 |=> pinOut == ($past(pinOut) | $past(wd));
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("set alias wrong");
  property p_latch_clear;
    regWr && regAddr == 8'h34 |=> pinOut == ($past(pinOut) & ~$past(wd));
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("clear alias wrong");
  property p_pullup_set;
    regWr && regAddr == 8'h58 |=> pullUpEn == ($past(pullUpEn) | $past(wd)) && $stable(pullDownEn);
  endproperty
  a_pullup_set: assert property (p_pullup_set) else $error("pull enables wrong");
  property p_alias_read;
    regRd && regAddr[3:0] != 4'h0 |=> regRdata == 32'h0000_0000;
  endproperty
  a_alias_read: assert property (p_alias_read) else $error("alias read not zero");
endmodule : port_io_change_notify_sva

bind port_io_change_notify port_io_change_notify_sva port_io_change_notify_sva_i (
  .ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata), .pinOut(pinOut), .pinOe(pinOe), .pullUpEn(pullUpEn),
  .pullDownEn(pullDownEn), .analogEn(analogEn));

/* dv/tb.sv */
`timescale 1ns/10ps
module tb;
  logic ref_clk, rstn, regWr, regRd, changeIrq, irq;
  logic [7:0]  regAddr;
  logic [31:0] regWdata, regRdata;
  logic [15:0] pinIn, pinOut, pinOe, pullUpEn, pullDownEn, analogEn, extVal, extEn;
  int errors = 0;
  int nCompared = 0;
  port_io_change_notify port_io_change_notify_i (.ref_clk(ref_clk), .rstn(rstn),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pullUpEn(pullUpEn),
    .pullDownEn(pullDownEn), .analogEn(analogEn), .changeIrq(changeIrq), .irq(irq));
  pin_partner pin_partner_i (.ref_clk(ref_clk), .drvVal(pinOut), .drvEn(pinOe),
    .pullUp(pullUpEn), .pullDn(pullDownEn), .extVal(extVal), .extEn(extEn), .level(pinIn));
  task automatic finish_test;
    if (errors == 0 && nCompared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regAddr  <= a;
    regWdata <= {16'h0000, d};
    regWr    <= 1'b1;
    @(posedge ref_clk);
    regWr    <= 1'b0;
    @(negedge ref_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge ref_clk);
    regRd   <= 1'b0;
    @(negedge ref_clk);
    chk(regRdata, e);
  endtask : rd
  task automatic pins(input logic [15:0] v);
    @(posedge ref_clk);
    extVal <= v;
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : pins
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    #100000;
    errors++;
    finish_test();
  end
  initial begin
    rstn     = 1'b0;
    regAddr  = 8'h00;
    regWdata = 32'h0000_0000;
    regWr    = 1'b0;
    regRd    = 1'b0;
    extVal   = 16'h3C00;
    extEn    = 16'hFF00;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(8'h00, 32'h0000_FFFF);
    rd(8'h10, 32'h0000_FFFF);
    chk({16'h0000, analogEn}, 32'h0000_FFFF);
    chk({16'h0000, pinOe}, 32'h0000_0000);
    rd(8'h34, 32'h0000_0000);
    rd(8'hC0, 32'h0000_0000);
    wr(8'h04, 16'hFFFF);
    wr(8'h10, 16'hFF00);
    chk({16'h0000, pinOe}, 32'h0000_00FF);
    wr(8'h30, 16'h00A5);
    rd(8'h30, 32'h0000_00A5);
    wr(8'h20, 16'h005A);
    rd(8'h30, 32'h0000_005A);
    wr(8'h38, 16'h0100);
    rd(8'h30, 32'h0000_015A);
    wr(8'h34, 16'h0002);
    rd(8'h30, 32'h0000_0158);
    wr(8'h3C, 16'h00FF);
    rd(8'h30, 32'h0000_01A7);
    rd(8'h20, 32'h0000_3CA7);
    wr(8'h40, 16'h0001);
    chk({16'h0000, pinOe}, 32'h0000_00FE);
    wr(8'h18, 16'h0001);
    wr(8'h58, 16'h0001);
    wr(8'h68, 16'h0100);
    chk({pullDownEn, pullUpEn}, 32'h0100_0001);
    pins(16'hBC00);
    wr(8'h08, 16'h8080);
    chk({16'h0000, analogEn}, 32'h0000_8080);
    chk({16'h0000, pinOe}, 32'h0000_00FE);
    rd(8'h20, 32'h0000_3CA7);
    wr(8'h78, 16'h8000);
    wr(8'h80, 16'h0200);
    rd(8'h20, 32'h0000_3CA7);
    rd(8'h90, 32'h0000_0000);
    pins(16'hB800);
    chk({31'h0, changeIrq}, 32'h0000_0000);
    pins(16'hBA00);
    chk({31'h0, changeIrq}, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(8'hB0, 16'h0001);
    chk({31'h0, irq}, 32'h0000_0001);
    rd(8'h90, 32'h0000_0600);
    rd(8'h20, 32'h0000_3AA7);
    chk({31'h0, changeIrq}, 32'h0000_0000);
    rd(8'hA0, 32'h0000_0001);
    rd(8'hA0, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk({16'h0000, pinOe}, 32'h0000_0000);
    rstn <= 1'b1;
    rd(8'h00, 32'h0000_FFFF);
    rd(8'h10, 32'h0000_FFFF);
    rd(8'h30, 32'h0000_0000);
    finish_test();
  end
endmodule : tb
